// ### logic/mbcl_pkg.sv
// Shared constants and types for the multibank command legality tracker
package mbcl_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100; // Core clock period, 10 MHz
    localparam int T_RCD_NS = 18; // Row-to-column delay, plain default
    localparam int T_RP_NS = 18; // Precharge time, plain default
    localparam int T_INIT_NS = 1000; // Self initialisation after reset, plain default
    // Least times round up, never below one cycle
    localparam int RCD_CYC = ((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int RP_CYC = ((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int INIT_CYC = ((T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int MRR_CYC = 2; // Mode register read time in clocks
    localparam int MRW_CYC = 5; // Mode register write time in clocks
    localparam int BURST_CYC = 2; // Clocks per burst (BL4 double rate)

    // ------------------------------------------------------------
    // Geometry and encodings
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 8; // Banks in the device
    localparam int BANK_W = 3; // Bank address width
    localparam int CNT_W = 8; // Width of every down counter
    localparam int DQ_W = 16; // Write data width
    localparam int LANES = 2; // Byte lanes, one mask bit each
    localparam logic [7:0] MR_RESET_ADDR = 8'h3f; // Mode register write that resets

    // Decoded command from the command/address decoder
    typedef enum logic [3:0] {
        CMD_NOP = 4'b0000,
        CMD_ACT = 4'b0001,
        CMD_RD = 4'b0010,
        CMD_WR = 4'b0011,
        CMD_PRE = 4'b0100,
        CMD_BST = 4'b0101,
        CMD_MRR = 4'b0110,
        CMD_MRW = 4'b0111,
        CMD_REF = 4'b1000,
        CMD_SREF = 4'b1001
    } mbcl_cmd_t;

    // Per-bank state
    typedef enum logic [2:0] {
        BK_IDLE = 3'b000,
        BK_ACTIVATING = 3'b001,
        BK_ACTIVE = 3'b010,
        BK_READING = 3'b011,
        BK_WRITING = 3'b100,
        BK_RD_AP = 3'b101,
        BK_WR_AP = 3'b110,
        BK_PRECHARGING = 3'b111
    } mbcl_bank_t;

    // Device-wide state
    typedef enum logic [2:0] {
        DV_POWER_ON = 3'b000,
        DV_RESETTING = 3'b001,
        DV_NORMAL = 3'b010,
        DV_MRR_IDLE = 3'b011,
        DV_MRR_RESET = 3'b100,
        DV_MRR_ACTIVE = 3'b101,
        DV_MRW = 3'b110
    } mbcl_dev_t;

endpackage

// ### logic/mbcl_bank.sv
// One bank's state machine with its own remaining-time counter
module mbcl_bank
    import mbcl_pkg::*;
#(
    parameter int RCD_CYCLES = RCD_CYC, // Row-to-column delay in clocks
    parameter int RP_CYCLES = RP_CYC // Precharge time in clocks
)
(
    input wire logic core_clk, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic go_act, // Accepted activate to this bank
    input wire logic go_rd, // Accepted read to this bank
    input wire logic go_wr, // Accepted write to this bank
    input wire logic go_ap, // Auto precharge with the read or write
    input wire logic go_pre, // Accepted precharge covering this bank
    input wire logic burst_end, // This bank's burst completed or terminated
    input wire logic force_idle, // Device reset drops the bank to idle
    output mbcl_bank_t state // Current bank state
);

    // ------------------------------------------------------------
    // State and counter
    // ------------------------------------------------------------
    mbcl_bank_t next_state; // Next bank state
    logic [CNT_W-1:0] cnt; // Remaining clocks of a timed state
    logic [CNT_W-1:0] next_cnt; // Next counter value

    // Next state; a new command wins over a burst ending in the same clock
    always_comb
    begin
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        case (state)
            BK_IDLE:
            begin
                if (go_act)
                begin
                    next_state = BK_ACTIVATING;
                    next_cnt = CNT_W'(RCD_CYCLES - 1);
                end
                else if (go_pre)
                begin
                    // Precharge of an idle bank still costs the precharge time
                    next_state = BK_PRECHARGING;
                    next_cnt = CNT_W'(RP_CYCLES - 1);
                end
            end
            BK_ACTIVATING:
            begin
                if (cnt == '0)
                    next_state = BK_ACTIVE;
            end
            BK_ACTIVE, BK_READING, BK_WRITING:
            begin
                if (go_rd)
                    next_state = go_ap ? BK_RD_AP : BK_READING;
                else if (go_wr)
                    next_state = go_ap ? BK_WR_AP : BK_WRITING;
                else if (go_pre)
                begin
                    next_state = BK_PRECHARGING;
                    next_cnt = CNT_W'(RP_CYCLES - 1);
                end
                else if (burst_end && state != BK_ACTIVE)
                    next_state = BK_ACTIVE;
            end
            BK_RD_AP, BK_WR_AP:
            begin
                // Auto precharge starts when the burst is over
                if (burst_end)
                begin
                    next_state = BK_PRECHARGING;
                    next_cnt = CNT_W'(RP_CYCLES - 1);
                end
            end
            BK_PRECHARGING:
            begin
                if (cnt == '0)
                    next_state = BK_IDLE;
            end
            default:
                next_state = BK_IDLE;
        endcase
        if (force_idle)
        begin
            next_state = BK_IDLE;
            next_cnt = '0;
        end
    end

    // Register the bank state
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state <= BK_IDLE;
            cnt <= '0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

endmodule // mbcl_bank

// ### logic/mbcl_top.sv
// Device-side tracker of bank states and cross-bank command legality
module mbcl_top
    import mbcl_pkg::*;
#(
    parameter int BANKS = NUM_BANKS, // Number of banks
    parameter int INIT_CYCLES = INIT_CYC // Self initialisation time in clocks
)
(
    input wire logic core_clk, // Core clock, 10 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic cmd_valid, // Decoded command present this clock
    input mbcl_pkg::mbcl_cmd_t cmd_code, // Decoded command
    input wire logic [mbcl_pkg::BANK_W-1:0] cmd_bank, // Target bank
    input wire logic cmd_ap, // Auto precharge or precharge-all flag
    input wire logic [7:0] cmd_mr_addr, // Mode register address for MRR/MRW
    input wire logic cke_prev, // Clock enable of previous cycle
    input wire logic cke_now, // Clock enable of this cycle
    input wire logic wr_valid, // Write data word present
    input wire logic [mbcl_pkg::DQ_W-1:0] wr_data, // Write data word
    input wire logic [mbcl_pkg::LANES-1:0] wr_mask, // Mask, high blocks a lane
    output logic [3*mbcl_pkg::NUM_BANKS-1:0] bank_states, // Packed bank states
    output mbcl_pkg::mbcl_dev_t dev_state, // Device-wide state
    output logic cmd_reject, // Pulse: last command refused
    output logic burst_active, // A read or write burst is running
    output logic [mbcl_pkg::LANES-1:0] wr_lane_en, // Lanes written this clock
    output logic [mbcl_pkg::DQ_W-1:0] wr_data_q // Registered write data
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mbcl_bank_t bank_st [BANKS]; // Per-bank states from the bank machines
    logic [BANKS-1:0] bank_idle; // Bank is idle
    logic [BANKS-1:0] bank_pre_ok; // Bank may be precharged
    logic all_idle; // Every bank idle and no burst
    logic live; // Command counts this clock
    logic legal; // Command is supported in current state
    logic accept; // Command accepted
    logic end_evt; // Current burst ends this clock
    mbcl_dev_t next_dev; // Next device state
    logic [CNT_W-1:0] dev_cnt; // Remaining clocks of a device state
    logic [CNT_W-1:0] next_dev_cnt; // Next device counter
    logic [BANK_W-1:0] burst_bank; // Bank of the most recent burst
    logic [BANK_W-1:0] next_burst_bank; // Next burst bank
    logic burst_wr; // Current burst is a write
    logic next_burst_wr; // Next burst direction
    logic next_burst_active; // Next burst flag
    logic [CNT_W-1:0] burst_cnt; // Remaining clocks of the burst
    logic [CNT_W-1:0] next_burst_cnt; // Next burst counter
    logic next_reject; // Next reject pulse
    logic [LANES-1:0] next_lane_en; // Next lane enables

    // ------------------------------------------------------------
    // Bank machines
    // ------------------------------------------------------------
    // Each bank keeps its own timer, so MRR leaves its result to the bank
    for (genvar b = 0; b < BANKS; b++)
    begin : g_bank
        logic hit; // Command targets this bank
        assign hit = (cmd_bank == BANK_W'(b));
        mbcl_bank #(
            .RCD_CYCLES(RCD_CYC),
            .RP_CYCLES(RP_CYC)
        ) u_bank (
            .core_clk(core_clk),
            .srst(srst),
            .go_act(accept && cmd_code == CMD_ACT && hit),
            .go_rd(accept && cmd_code == CMD_RD && hit),
            .go_wr(accept && cmd_code == CMD_WR && hit),
            .go_ap(cmd_ap),
            .go_pre(accept && cmd_code == CMD_PRE && (hit || cmd_ap)),
            .burst_end(end_evt && burst_bank == BANK_W'(b)),
            .force_idle(accept && next_dev == DV_RESETTING),
            .state(bank_st[b])
        );
        assign bank_idle[b] = (bank_st[b] == BK_IDLE);
        assign bank_pre_ok[b] = (bank_st[b] != BK_RD_AP) && (bank_st[b] != BK_WR_AP)
            && (bank_st[b] != BK_ACTIVATING);
        assign bank_states[3*b +: 3] = bank_st[b];
    end

    // ------------------------------------------------------------
    // Legality check
    // ------------------------------------------------------------
    // Clock enable low in either cycle makes the command a NOP
    assign live = cmd_valid && cmd_code != CMD_NOP && cke_prev && cke_now;
    assign all_idle = (&bank_idle) && !burst_active;

    // Decide whether the command is supported; anything else is refused
    always_comb
    begin
        legal = 1'b0;
        case (dev_state)
            DV_POWER_ON:
                legal = (cmd_code == CMD_MRW) && (cmd_mr_addr == MR_RESET_ADDR);
            DV_RESETTING:
                legal = (cmd_code == CMD_MRR);
            DV_NORMAL:
            begin
                case (cmd_code)
                    // Activate spacing is left to the controller
                    CMD_ACT: legal = bank_idle[cmd_bank];
                    CMD_RD: legal = !(burst_active && burst_wr)
                        && (bank_st[cmd_bank] inside {BK_ACTIVE, BK_READING, BK_WRITING});
                    CMD_WR: legal = !(burst_active && !burst_wr)
                        && (bank_st[cmd_bank] inside {BK_ACTIVE, BK_READING, BK_WRITING});
                    CMD_PRE: legal = cmd_ap ? (&bank_pre_ok) : bank_pre_ok[cmd_bank];
                    CMD_BST: legal = burst_active;
                    CMD_MRR: legal = !burst_active;
                    CMD_MRW, CMD_REF, CMD_SREF: legal = all_idle;
                    default: legal = 1'b0;
                endcase
            end
            default:
                legal = 1'b0;
        endcase
    end

    assign accept = live && legal;

    // ------------------------------------------------------------
    // Device state
    // ------------------------------------------------------------
    // Mode register states run a fixed time and then resolve
    always_comb
    begin
        next_dev = dev_state;
        next_dev_cnt = (dev_cnt != '0) ? dev_cnt - 1'b1 : dev_cnt;
        case (dev_state)
            DV_POWER_ON, DV_NORMAL:
            begin
                if (accept && cmd_code == CMD_MRW)
                begin
                    if (cmd_mr_addr == MR_RESET_ADDR)
                    begin
                        next_dev = DV_RESETTING;
                        next_dev_cnt = CNT_W'(INIT_CYCLES - 1);
                    end
                    else
                    begin
                        next_dev = DV_MRW;
                        next_dev_cnt = CNT_W'(MRW_CYC - 1);
                    end
                end
                else if (accept && cmd_code == CMD_MRR)
                begin
                    // Idle banks give idle MRR, otherwise banks keep their own state
                    next_dev = all_idle ? DV_MRR_IDLE : DV_MRR_ACTIVE;
                    next_dev_cnt = CNT_W'(MRR_CYC - 1);
                end
            end
            DV_RESETTING:
            begin
                if (accept)
                begin
                    next_dev = DV_MRR_RESET;
                    next_dev_cnt = CNT_W'(MRR_CYC - 1);
                end
                else if (dev_cnt == '0)
                    next_dev = DV_NORMAL;
            end
            DV_MRR_IDLE, DV_MRR_RESET, DV_MRR_ACTIVE, DV_MRW:
            begin
                // Banks stay as they were, so active MRR returns to active
                if (dev_cnt == '0)
                    next_dev = DV_NORMAL;
            end
            default:
                next_dev = DV_POWER_ON;
        endcase
    end

    // ------------------------------------------------------------
    // Burst tracking
    // ------------------------------------------------------------
    // Burst ends by running out, by terminate, or by a new burst elsewhere
    assign end_evt = burst_active && ((burst_cnt == '0)
        || (accept && cmd_code == CMD_BST)
        || (accept && (cmd_code == CMD_RD || cmd_code == CMD_WR) && cmd_bank != burst_bank));

    // Next burst bookkeeping; a new burst wins over an ending one
    always_comb
    begin
        next_burst_active = burst_active && !end_evt;
        next_burst_bank = burst_bank;
        next_burst_wr = burst_wr;
        next_burst_cnt = (burst_cnt != '0) ? burst_cnt - 1'b1 : burst_cnt;
        if (accept && (cmd_code == CMD_RD || cmd_code == CMD_WR))
        begin
            next_burst_active = 1'b1;
            next_burst_bank = cmd_bank;
            next_burst_wr = (cmd_code == CMD_WR);
            next_burst_cnt = CNT_W'(BURST_CYC - 1);
        end
        next_reject = live && !legal;
        // Masked lanes are dropped; data on them is ignored
        next_lane_en = (wr_valid && burst_active && burst_wr) ? ~wr_mask : '0;
    end

    // Register device state, burst bookkeeping and outputs
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            dev_state <= DV_POWER_ON;
            dev_cnt <= '0;
            burst_active <= 1'b0;
            burst_bank <= '0;
            burst_wr <= 1'b0;
            burst_cnt <= '0;
            cmd_reject <= 1'b0;
            wr_lane_en <= '0;
            wr_data_q <= '0;
        end
        else
        begin
            dev_state <= next_dev;
            dev_cnt <= next_dev_cnt;
            burst_active <= next_burst_active;
            burst_bank <= next_burst_bank;
            burst_wr <= next_burst_wr;
            burst_cnt <= next_burst_cnt;
            cmd_reject <= next_reject;
            wr_lane_en <= next_lane_en;
            wr_data_q <= wr_data;
        end
    end

endmodule // mbcl_top

// ### test/mbcl_checker.sv
// Port-level checks for the bank state tracker
module mbcl_checker
    import mbcl_pkg::*;
#(
    parameter int BANKS = NUM_BANKS, // Number of banks
    parameter int INIT_CYCLES = INIT_CYC // Init time
)
(
    input wire logic core_clk, // Core clock
    input wire logic srst, // Reset
    input wire logic cmd_valid, // Command present
    input mbcl_pkg::mbcl_cmd_t cmd_code, // Command
    input wire logic [mbcl_pkg::BANK_W-1:0] cmd_bank, // Target bank
    input wire logic cmd_ap, // Precharge flag
    input wire logic [7:0] cmd_mr_addr, // Register address
    input wire logic cke_prev, // Enable, last cycle
    input wire logic cke_now, // Enable, this cycle
    input wire logic wr_valid, // Word present
    input wire logic [mbcl_pkg::DQ_W-1:0] wr_data, // Write word
    input wire logic [mbcl_pkg::LANES-1:0] wr_mask, // Lane mask
    input wire logic [3*mbcl_pkg::NUM_BANKS-1:0] bank_states, // Bank states
    input mbcl_pkg::mbcl_dev_t dev_state, // Device state
    input wire logic cmd_reject, // Refusal pulse
    input wire logic burst_active, // Burst running
    input wire logic [mbcl_pkg::LANES-1:0] wr_lane_en, // Lanes written
    input wire logic [mbcl_pkg::DQ_W-1:0] wr_data_q // Write word out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // Helper decode
    // ----------------
    logic taken; // Command counts
    logic all_idle; // Every bank idle
    logic any_wr; // A bank is writing
    logic lane_ok; // Word in a write burst
    // Scan all banks in a plain loop
    always_comb
    begin
        all_idle = 1'b1;
        any_wr = 1'b0;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            all_idle = all_idle & (bank_states[3*b +: 3] == BK_IDLE);
            any_wr = any_wr | (bank_states[3*b +: 3] inside {BK_WRITING, BK_WR_AP});
        end
    end
    assign taken = cmd_valid && cmd_code != CMD_NOP && cke_prev && cke_now;
    assign lane_ok = wr_valid && burst_active && any_wr;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // ----------------
    // Assertions
    // ----------------
    for (genvar b = 0; b < NUM_BANKS; b++)
    begin : g_bank
        chk_row_delay: assert property (
            bank_states[3*b +: 3] == BK_ACTIVATING |=> bank_states[3*b +: 3] == BK_ACTIVE)
            else $error("Bank not open after row delay");
        chk_pre_time: assert property (
            bank_states[3*b +: 3] == BK_PRECHARGING |=> bank_states[3*b +: 3] == BK_IDLE)
            else $error("Bank not idle after precharge");
    end
    chk_lane_mask: assert property (
        !$past(srst) |-> wr_lane_en == ($past(lane_ok) ? ~$past(wr_mask) : '0))
        else $error("Lane enables miss the mask");
    chk_mode_nop: assert property (
        dev_state inside {DV_MRR_IDLE, DV_MRR_RESET, DV_MRR_ACTIVE, DV_MRW} && taken
        |=> cmd_reject)
        else $error("Command taken during register access");
    chk_mrr_done: assert property (
        dev_state inside {DV_MRR_IDLE, DV_MRR_RESET, DV_MRR_ACTIVE} && $changed(dev_state)
        |-> ##2 dev_state == DV_NORMAL)
        else $error("Register read overran");
    chk_mrw_done: assert property (
        dev_state == DV_MRW && $changed(dev_state)
        |-> dev_state == DV_MRW [*5] ##1 dev_state == DV_NORMAL)
        else $error("Register write overran");
    chk_bst_refuse: assert property (
        dev_state == DV_NORMAL && taken && cmd_code == CMD_BST && !burst_active |=> cmd_reject)
        else $error("Terminate without burst taken");
    chk_need_idle: assert property (
        dev_state == DV_NORMAL && taken && cmd_code inside {CMD_REF, CMD_SREF, CMD_MRW}
        && !all_idle |=> cmd_reject && $stable(dev_state))
        else $error("All-idle command taken, bank open");
    chk_reset_entry: assert property (
        dev_state == DV_POWER_ON && taken && cmd_code == CMD_MRW
        && cmd_mr_addr == MR_RESET_ADDR |=> dev_state == DV_RESETTING && bank_states == '0)
        else $error("Reset write did not reset");
endmodule // mbcl_checker

bind mbcl_top mbcl_checker #(.BANKS(BANKS), .INIT_CYCLES(INIT_CYCLES)) u_checker (
    .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_ap(cmd_ap), .cmd_mr_addr(cmd_mr_addr), .cke_prev(cke_prev),
    .cke_now(cke_now), .wr_valid(wr_valid), .wr_data(wr_data), .wr_mask(wr_mask),
    .bank_states(bank_states), .dev_state(dev_state), .cmd_reject(cmd_reject),
    .burst_active(burst_active), .wr_lane_en(wr_lane_en), .wr_data_q(wr_data_q)
);

// ### test/mbcl_host.sv
// Controller model: commands and write data
module mbcl_host
    import mbcl_pkg::*;
(
    input wire logic core_clk, // Core clock
    output logic cmd_valid, // Command present
    output mbcl_pkg::mbcl_cmd_t cmd_code, // Command
    output logic [mbcl_pkg::BANK_W-1:0] cmd_bank, // Target bank
    output logic cmd_ap, // Precharge flag
    output logic [7:0] cmd_mr_addr, // Register address
    output logic cke_prev, // Enable, last cycle
    output logic cke_now, // Enable, this cycle
    output logic wr_valid, // Word present
    output logic [mbcl_pkg::DQ_W-1:0] wr_data, // Write word
    output logic [mbcl_pkg::LANES-1:0] wr_mask // Lane mask, high blocks
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero, enable high
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = CMD_NOP;
        {cmd_bank, cmd_ap, cmd_mr_addr, wr_valid, wr_data, wr_mask} = '0;
        {cke_prev, cke_now} = 2'b11;
    end
    // One command at the next edge, back to back allowed
    task automatic send(input mbcl_cmd_t c, input logic [BANK_W-1:0] b,
        input logic ap = 1'b0, input logic [7:0] mr = 8'h00, input logic ck = 1'b1);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_bank <= b;
        cmd_ap <= ap;
        cmd_mr_addr <= mr;
        cke_prev <= cke_now;
        cke_now <= ck;
        #1;
    endtask
    // Back to NOP; cmd_bank and unused wr_data toggle so stale data never matches
    task automatic done(input logic v = 1'b0, input logic [DQ_W-1:0] d = '0,
        input logic [LANES-1:0] m = '0);
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_code <= CMD_NOP;
        cmd_bank <= ~cmd_bank;
        cke_prev <= cke_now;
        cke_now <= 1'b1;
        wr_valid <= v;
        wr_data <= v ? d : ~wr_data;
        wr_mask <= m;
        #1;
    endtask
endmodule // mbcl_host

// ### test/multibank_command_legality_test.sv
// Self-checking bench for the bank tracker
module multibank_command_legality_test;
    timeunit 1ns;
    timeprecision 100ps;
    import mbcl_pkg::*;
    logic core_clk = 1'b0; // Core clock
    logic srst = 1'b1; // Synchronous reset
    logic cmd_valid, cmd_ap, cke_prev, cke_now, wr_valid; // Host controls
    mbcl_cmd_t cmd_code; // Command
    logic [BANK_W-1:0] cmd_bank; // Target bank
    logic [7:0] cmd_mr_addr; // Register address
    logic [DQ_W-1:0] wr_data, wr_data_q; // Write word in and out
    logic [LANES-1:0] wr_mask, wr_lane_en; // Mask in, lane enables out
    logic [3*NUM_BANKS-1:0] bank_states; // Packed bank states
    mbcl_dev_t dev_state; // Device state
    logic cmd_reject, burst_active; // Refusal pulse, burst flag
    int n_mismatch = 0; // Mismatches seen
    int total_checks = 0; // Comparisons made
    always #50 core_clk = ~core_clk;
    mbcl_host host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_bank(cmd_bank), .cmd_ap(cmd_ap), .cmd_mr_addr(cmd_mr_addr), .cke_prev(cke_prev),
        .cke_now(cke_now), .wr_valid(wr_valid), .wr_data(wr_data), .wr_mask(wr_mask));
    mbcl_top dut (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_bank(cmd_bank), .cmd_ap(cmd_ap), .cmd_mr_addr(cmd_mr_addr), .cke_prev(cke_prev),
        .cke_now(cke_now), .wr_valid(wr_valid), .wr_data(wr_data), .wr_mask(wr_mask),
        .bank_states(bank_states), .dev_state(dev_state), .cmd_reject(cmd_reject),
        .burst_active(burst_active), .wr_lane_en(wr_lane_en), .wr_data_q(wr_data_q));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [2:0] bk(input int b);
        return bank_states[3*b +: 3];
    endfunction
    task automatic eq(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------
    // Scenarios
    // ----------------
    // Power-on refusal, reset, read while resetting
    task automatic t_power_up();
        eq(dev_state, DV_POWER_ON);
        host.send(CMD_ACT, 3'h0);
        host.done();
        eq(cmd_reject, 1'b1);
        host.send(CMD_MRW, 3'h0, 1'b0, MR_RESET_ADDR);
        host.done();
        eq(dev_state, DV_RESETTING);
        host.send(CMD_MRR, 3'h0);
        host.done();
        eq(dev_state, DV_MRR_RESET);
        tick(2);
        eq(dev_state, DV_NORMAL);
    endtask
    // Register reads on activating, precharging banks
    task automatic t_act_mrr();
        host.send(CMD_ACT, 3'h2);
        host.send(CMD_MRR, 3'h0);
        host.done();
        eq(cmd_reject, 1'b0);
        eq(dev_state, DV_MRR_ACTIVE);
        eq(bk(2), BK_ACTIVE);
        host.send(CMD_ACT, 3'h4);
        host.done();
        eq(cmd_reject, 1'b1);
        eq(dev_state, DV_NORMAL);
        host.send(CMD_PRE, 3'h2);
        host.send(CMD_MRR, 3'h0);
        host.done();
        eq(cmd_reject, 1'b0);
        eq(bk(2), BK_IDLE);
        tick(2);
        eq(dev_state, DV_NORMAL);
    endtask
    // Cross-bank read/write exclusion, terminate, write masking
    task automatic t_rd_wr();
        host.send(CMD_ACT, 3'h1);
        host.send(CMD_ACT, 3'h3);
        host.done();
        tick(1);
        host.send(CMD_RD, 3'h1);
        host.send(CMD_WR, 3'h3);
        host.send(CMD_NOP, 3'h0);
        eq(cmd_reject, 1'b1);
        eq(bk(1), BK_READING);
        eq(bk(3), BK_ACTIVE);
        host.done();
        host.send(CMD_RD, 3'h1);
        host.send(CMD_BST, 3'h1);
        host.done();
        eq(bk(1), BK_ACTIVE);
        eq(burst_active, 1'b0);
        host.send(CMD_BST, 3'h1);
        host.done();
        eq(cmd_reject, 1'b1);
        host.send(CMD_WR, 3'h3);
        host.send(CMD_RD, 3'h1);
        host.done(1'b1, 16'h5a3c, 2'b01);
        eq(cmd_reject, 1'b1);
        tick(1);
        eq(wr_lane_en, 2'b10);
        eq(wr_data_q, 16'h5a3c);
        host.done();
        eq(wr_lane_en, 2'b00);
    endtask
    // All-idle commands, precharge all, register write, idle read
    task automatic t_all_idle();
        host.send(CMD_REF, 3'h0);
        host.done();
        eq(cmd_reject, 1'b1);
        host.send(CMD_MRW, 3'h0, 1'b0, 8'h01);
        host.done();
        eq(cmd_reject, 1'b1);
        host.send(CMD_PRE, 3'h0, 1'b1);
        host.done();
        eq(bk(3), BK_PRECHARGING);
        tick(1);
        eq(bank_states, 24'h0);
        host.send(CMD_MRW, 3'h0, 1'b0, 8'h01);
        host.done();
        eq(dev_state, DV_MRW);
        host.send(CMD_ACT, 3'h0);
        host.done();
        eq(cmd_reject, 1'b1);
        tick(3);
        eq(dev_state, DV_NORMAL);
        host.send(CMD_MRR, 3'h0);
        host.done();
        eq(dev_state, DV_MRR_IDLE);
    endtask
    // Enable gating, other bank after auto precharge
    task automatic t_cke_ap();
        host.send(CMD_ACT, 3'h5, 1'b0, 8'h00, 1'b0);
        host.done();
        eq(bk(5), BK_IDLE);
        eq(cmd_reject, 1'b0);
        host.send(CMD_ACT, 3'h5);
        host.done();
        tick(1);
        host.send(CMD_RD, 3'h5, 1'b1);
        host.done();
        eq(bk(5), BK_RD_AP);
        host.send(CMD_ACT, 3'h6);
        host.done();
        eq(bk(6), BK_ACTIVATING);
    endtask
    // Three reset edges, then the scenarios
    initial
    begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        t_power_up();
        t_act_mrr();
        t_rd_wr();
        t_all_idle();
        t_cke_ap();
        wrap_up();
    end
    // Watchdog: run needs ~70 cycles
    initial
    begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
endmodule // multibank_command_legality_test
